// [logic/piu_pkg.sv]
package piu_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] PIU_OFF_CTRL = 8'h00; // control word
  localparam logic [7:0] PIU_OFF_STATUS = 8'h01; // status index
  localparam logic [7:0] PIU_OFF_NMICTL = 8'h02; // non-maskable control
  localparam logic [7:0] PIU_OFF_NMIFLG = 8'h03; // non-maskable flag
  localparam logic [7:0] PIU_OFF_EVOUT = 8'h04; // event output enables
  localparam logic [7:0] PIU_OFF_IENCLR = 8'h08; // enable clear
  localparam logic [7:0] PIU_OFF_IENSET = 8'h0c; // enable set
  localparam logic [7:0] PIU_OFF_FLAG = 8'h10; // pin flags
  localparam logic [7:0] PIU_OFF_WAKE = 8'h14; // wake enables
  localparam logic [7:0] PIU_OFF_CFG0 = 8'h18; // config pins 0..7
  localparam logic [7:0] PIU_OFF_CFG1 = 8'h1c; // config pins 8..15
  // ----------------------------------------------------------------
  // byte addresses (offsets all word aligned: index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIU_IDX_SHIFT = 8'h02; // index to byte address
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PIU_CTL_SOFT_RESET_BIT = 0; // soft reset bit
  localparam int PIU_CTRL_EN = 1; // enable bit
  localparam int PIU_STAT_BUSY = 7; // sync pending bit
  localparam int PIU_FILT_BIT = 3; // filter bit within nibble
  localparam int PIU_CFG_W = 4; // config nibble width
  // ----------------------------------------------------------------
  // sense encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PIU_SNS_NONE = 3'h0; // no detection
  localparam logic [2:0] PIU_SNS_RISE = 3'h1; // rising edge
  localparam logic [2:0] PIU_SNS_FALL = 3'h2; // falling edge
  localparam logic [2:0] PIU_SNS_BOTH = 3'h3; // both edges
  localparam logic [2:0] PIU_SNS_HIGH = 3'h4; // high level
  localparam logic [2:0] PIU_SNS_LOW = 3'h5; // low level
  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] PIU_RST_WORD = 32'h0000_0000; // all registers
  localparam logic [1:0] PIU_RESP_OK = 2'h0; // okay
  localparam logic [1:0] PIU_RESP_ERR = 2'h2; // slave error
  localparam int PIU_NPINS = 16; // pin count
  localparam int PIU_SYNC_CYC = 2; // busy cycles per synced write
  // bus write state machine
  typedef enum logic [1:0] {
    PIU_W_IDLE = 2'b00,
    PIU_W_RESP = 2'b01
  } piu_wst_e;
endpackage : piu_pkg

// [logic/piu_top.sv]
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] keeps running while cpu is halted
// [RULE2] guard blocks writes except flags, debugger
// [RULE3] software: bus clock, detect clock, config, enable
// [RULE4] software: nonmask config before detect clock
// [RULE5] enable bit enables and disables unit
// [RULE6] soft reset clears registers, disables unit
// [RULE7] per-pin sense: rise, fall, both, levels
// [RULE8] edge flag resets only on fresh edge
// [RULE9] level flag resets at once if held
// [RULE10] filter only when filter bit is one
// [RULE11] majority of three samples
// [RULE12] level unfiltered needs no detect clock
// [RULE13] edge or filter requests detect clock
// [RULE14] bounded detection latency per mode
// [RULE15] nonmask sense alone enables its detection
// [RULE16] nonmask flag always drives its request
// [RULE17] software: clock for nonmask edge/filter
// [RULE18] set/clear registers gate pin interrupts
// [RULE19] request while flag set and enabled
// [RULE20] one request per pin plus nonmask
// [RULE21] shared channel driven by first pin; none built, each pin drives only its own pin_irq bit
// [RULE22] event enable gates per-pin events
// [RULE23] sixteen pins plus one nonmask pin
// [RULE24] busy set during enable/reset sync
// [RULE25] wake on match when wake bit set
// [RULE26] write one clears flag, zero keeps
module piu_top
  import piu_pkg::*;
#(
  parameter int NPINS = piu_pkg::PIU_NPINS // RULE23
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en, // freezes all state when low
  input wire logic dbg_access, // write comes from external debugger
  input wire logic guard_lock, // bus write guard active
  input wire logic [NPINS-1:0] ext_irq_pin, // raw pins
  input wire logic nonmask_pin, // raw non-maskable pin
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NPINS-1:0] pin_irq, // one request per pin
  output logic nonmask_irq, // non-maskable request
  output logic [NPINS-1:0] pin_event, // event outputs, one-cycle pulse per edge, held while a level sense matches
  output logic [NPINS-1:0] pin_wake, // wake requests
  output logic detect_clk_req // detection clock request
);
  import piu_pkg::*;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic enable_ff; // unit enable
  logic [1:0] busy_cnt_ff; // sync pending countdown
  logic [3:0] nmictl_ff; // non-maskable control
  logic nonmask_flag_reg_ff; // non-maskable flag
  logic [NPINS-1:0] evout_ff; // event enables
  logic [NPINS-1:0] ien_ff; // interrupt enables
  logic [NPINS-1:0] flag_ff; // pin flags
  logic [NPINS-1:0] wake_ff; // wake enables
  logic [4*NPINS-1:0] cfg_ff; // per-pin sense and filter
  logic [NPINS:0] s1_ff, s2_ff, s3_ff, s4_ff; // sync and samples
  logic [NPINS:0] prev_ff; // previous detector input
  logic [NPINS:0] det; // per-source detection
  logic [NPINS:0] din; // detector input after filter
  logic [NPINS:0] any_clk; // source needs detection clock
  // bus handshake state
  piu_wst_e wst_ff;
  logic aw_ok_ff, w_ok_ff; // captured address and data
  logic [31:0] awaddr_ff, wdata_ff;
  logic wr_go; // write commits this cycle
  logic soft_rst; // soft reset strobe
  logic [7:0] widx; // decoded write index
  logic wr_err; // unmapped write
  logic [NPINS-1:0] wr_flag_clr; // flag clear mask
  logic wr_nmi_clr; // nonmask clear
  logic guard_blk; // guard blocks this write
  assign wr_go = clk_en && (wst_ff == PIU_W_IDLE) && aw_ok_ff && w_ok_ff;
  // awaddr_ff already holds the register index, not the byte address
  assign widx = awaddr_ff[7:0];
  assign guard_blk = guard_lock && !dbg_access; // RULE2
  assign soft_rst = wr_go && !guard_blk && widx == PIU_OFF_CTRL
    && wdata_ff[PIU_CTL_SOFT_RESET_BIT]; // RULE6
  assign wr_err = !(widx <= PIU_OFF_CFG1 && (widx < 8'h05
    || widx[1:0] == 2'h0));
  // flag registers stay writable under the guard
  assign wr_flag_clr = (wr_go && widx == PIU_OFF_FLAG) ?
    wdata_ff[NPINS-1:0] : '0; // RULE2 RULE26
  assign wr_nmi_clr = wr_go && widx == PIU_OFF_NMIFLG && wdata_ff[0];
  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PIU_RESP_OK;
      wst_ff <= PIU_W_IDLE;
    end else if (clk_en) begin
      // accept address once, in either order with data
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid
        && wst_ff == PIU_W_IDLE;
      s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid
        && wst_ff == PIU_W_IDLE;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr >> PIU_IDX_SHIFT;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      case (wst_ff)
        PIU_W_IDLE: begin
          if (aw_ok_ff && w_ok_ff) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? PIU_RESP_ERR : PIU_RESP_OK;
            wst_ff <= PIU_W_RESP;
          end
        end
        PIU_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_ff <= PIU_W_IDLE;
          end
        end
        default: wst_ff <= PIU_W_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // configuration registers, guarded
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || (clk_en && soft_rst)) begin // RULE6
      enable_ff <= 1'b0;
      nmictl_ff <= 4'h0;
      evout_ff <= '0;
      ien_ff <= '0;
      wake_ff <= '0;
      cfg_ff <= '0;
    end else if (clk_en && wr_go && !guard_blk) begin // RULE2
      case (widx)
        PIU_OFF_CTRL: enable_ff <= wdata_ff[PIU_CTRL_EN]; // RULE5
        PIU_OFF_NMICTL: nmictl_ff <= wdata_ff[3:0];
        PIU_OFF_EVOUT: evout_ff <= wdata_ff[NPINS-1:0]; // RULE22
        PIU_OFF_IENSET: ien_ff <= ien_ff | wdata_ff[NPINS-1:0]; // RULE18
        PIU_OFF_IENCLR: ien_ff <= ien_ff & ~wdata_ff[NPINS-1:0]; // RULE18
        PIU_OFF_WAKE: wake_ff <= wdata_ff[NPINS-1:0]; // RULE25
        PIU_OFF_CFG0: cfg_ff[31:0] <= wdata_ff;
        PIU_OFF_CFG1: cfg_ff[63:32] <= wdata_ff;
        default: enable_ff <= enable_ff;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // sync pending status for enable and soft reset writes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      if (wr_go && !guard_blk && widx == PIU_OFF_CTRL) begin
        busy_cnt_ff <= 2'(PIU_SYNC_CYC); // RULE24
      end else if (busy_cnt_ff != 2'h0) begin
        busy_cnt_ff <= busy_cnt_ff - 2'h1; // RULE24
      end
    end
  end
  // ----------------------------------------------------------------
  // pin synchronisers and filter samples (no debug halt input) RULE1
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      s4_ff <= '0;
      prev_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= {nonmask_pin, ext_irq_pin}; // RULE14
      s2_ff <= s1_ff; // RULE14
      s3_ff <= s2_ff; // RULE11
      s4_ff <= s3_ff; // RULE11
      prev_ff <= din;
    end
  end
  // ----------------------------------------------------------------
  // per-source detection, index NPINS is the non-maskable pin
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi <= NPINS; gi++) begin : g_det
      logic [2:0] sns; // selected sense
      logic filt; // filter on
      logic maj; // majority of three
      logic on; // detection allowed
      if (gi == NPINS) begin : g_nmi
        assign sns = nmictl_ff[2:0];
        assign filt = nmictl_ff[PIU_FILT_BIT];
        assign on = 1'b1; // RULE15
      end else begin : g_pin
        assign sns = cfg_ff[gi*PIU_CFG_W +: 3]; // RULE7
        assign filt = cfg_ff[gi*PIU_CFG_W + PIU_FILT_BIT];
        assign on = enable_ff;
      end
      assign maj = (s2_ff[gi] & s3_ff[gi]) | (s2_ff[gi] & s4_ff[gi])
        | (s3_ff[gi] & s4_ff[gi]); // RULE11
      assign din[gi] = filt ? maj : s2_ff[gi]; // RULE10
      assign any_clk[gi] = on && (filt || sns == PIU_SNS_RISE
        || sns == PIU_SNS_FALL || sns == PIU_SNS_BOTH); // RULE13
      // sense decode per source, edges against the previous sample
      always_comb begin
        case (sns) // RULE7 RULE8 RULE9 RULE12
          PIU_SNS_RISE: det[gi] = on && din[gi] && !prev_ff[gi];
          PIU_SNS_FALL: det[gi] = on && !din[gi] && prev_ff[gi];
          PIU_SNS_BOTH: det[gi] = on && (din[gi] != prev_ff[gi]);
          PIU_SNS_HIGH: det[gi] = on && din[gi];
          PIU_SNS_LOW: det[gi] = on && !din[gi];
          default: det[gi] = 1'b0;
        endcase
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // flags: set wins over clear; soft reset clears all
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || (clk_en && soft_rst)) begin
      flag_ff <= '0;
      nonmask_flag_reg_ff <= 1'b0;
    end else if (clk_en) begin
      flag_ff <= (flag_ff & ~wr_flag_clr) | det[NPINS-1:0]; // RULE26 RULE9
      nonmask_flag_reg_ff <= (nonmask_flag_reg_ff & !wr_nmi_clr) | det[NPINS]; // RULE16
    end
  end
  // ----------------------------------------------------------------
  // request, event, wake and clock request outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_irq <= '0;
      nonmask_irq <= 1'b0;
      pin_event <= '0;
      pin_wake <= '0;
      detect_clk_req <= 1'b0;
    end else if (clk_en) begin
      pin_irq <= flag_ff & ien_ff; // RULE19 RULE20 RULE21
      nonmask_irq <= nonmask_flag_reg_ff; // RULE16
      pin_event <= det[NPINS-1:0] & evout_ff; // RULE22
      pin_wake <= det[NPINS-1:0] & wake_ff; // RULE25
      detect_clk_req <= |any_clk; // RULE13
    end
  end
  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [31:0] rdat; // read mux
  logic rerr; // unmapped read
  logic [7:0] ridx; // read index
  assign ridx = 8'(s_axi_araddr[9:2]);
  // read mux, unmapped indices answer slave error and read zero
  always_comb begin
    rdat = PIU_RST_WORD;
    rerr = 1'b0;
    case (ridx)
      PIU_OFF_CTRL: rdat[PIU_CTRL_EN] = enable_ff;
      PIU_OFF_STATUS: rdat[PIU_STAT_BUSY] = busy_cnt_ff != 2'h0;
      PIU_OFF_NMICTL: rdat[3:0] = nmictl_ff;
      PIU_OFF_NMIFLG: rdat[0] = nonmask_flag_reg_ff;
      PIU_OFF_EVOUT: rdat[NPINS-1:0] = evout_ff;
      PIU_OFF_IENCLR: rdat[NPINS-1:0] = ien_ff;
      PIU_OFF_IENSET: rdat[NPINS-1:0] = ien_ff;
      PIU_OFF_FLAG: rdat[NPINS-1:0] = flag_ff;
      PIU_OFF_WAKE: rdat[NPINS-1:0] = wake_ff;
      PIU_OFF_CFG0: rdat = cfg_ff[31:0];
      PIU_OFF_CFG1: rdat = cfg_ff[63:32];
      default: rerr = 1'b1;
    endcase
  end
  // read answer registered at the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PIU_RESP_OK;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdat;
        s_axi_rresp <= rerr ? PIU_RESP_ERR : PIU_RESP_OK;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  irq_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> pin_irq == $past(flag_ff & ien_ff)) // RULE19
    else $error("pin request mismatch");
  nmi_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && nonmask_flag_reg_ff |=> nonmask_irq) // RULE16
    else $error("nonmask request missing");
  swrst_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && soft_rst |=> !enable_ff && ien_ff == '0) // RULE6
    else $error("soft reset left state");
  busy_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_go && !guard_blk && widx == PIU_OFF_CTRL
    |=> busy_cnt_ff != 2'h0 ##[1:4] busy_cnt_ff == 2'h0) // RULE24
    else $error("sync busy wrong");
  guard_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_go && guard_blk && !soft_rst |=> $stable(ien_ff)) // RULE2
    else $error("guard let write through");
  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !soft_rst && det[0] |=> flag_ff[0]) // RULE26
    else $error("flag set lost");
  event_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !evout_ff[0] |=> !pin_event[0]) // RULE22
    else $error("event not gated");
  level_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && enable_ff && cfg_ff[14:12] == PIU_SNS_HIGH && din[3]
    && !soft_rst |=> flag_ff[3]) // RULE9
    else $error("level flag not reset");
  // ----------------------------------------------------------------
  // further checks on clears, enables, the detection clock request and the non-maskable path
  // ----------------------------------------------------------------
  flag_clr_a: assert property ( // RULE26
    @(posedge aclk) disable iff (!aresetn)
    clk_en && wr_flag_clr[0] && !det[0] |=> !flag_ff[0])
    else $error("flag clear lost");
  ien_set_a: assert property ( // RULE18
    @(posedge aclk) disable iff (!aresetn)
    clk_en && wr_go && !guard_blk && widx == PIU_OFF_IENSET
    |=> (ien_ff & $past(wdata_ff[NPINS-1:0])) == $past(wdata_ff[NPINS-1:0]))
    else $error("enable set lost");
  clk_req_a: assert property ( // RULE13
    @(posedge aclk) disable iff (!aresetn)
    clk_en && enable_ff && cfg_ff[2:0] == PIU_SNS_RISE |=> detect_clk_req)
    else $error("detect clock not requested");
  nmi_free_a: assert property ( // RULE15
    @(posedge aclk) disable iff (!aresetn)
    clk_en && !soft_rst && !enable_ff && nmictl_ff[2:0] == PIU_SNS_RISE
    && din[NPINS] && !prev_ff[NPINS] |=> nonmask_flag_reg_ff)
    else $error("nonmask edge missed");
  wake_gate_a: assert property ( // RULE25
    @(posedge aclk) disable iff (!aresetn)
    clk_en && !wake_ff[1] |=> !pin_wake[1])
    else $error("wake not gated");
endmodule : piu_top

// [tb/piu_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// event router and wake sink seen from the unit's far side
// ----------------------------------------------------------------
module piu_host_model (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset, low active
  input wire logic [piu_pkg::PIU_NPINS-1:0] pin_event, // event lines
  input wire logic [piu_pkg::PIU_NPINS-1:0] pin_wake, // wake lines
  output logic [piu_pkg::PIU_NPINS-1:0][7:0] ev_cnt_ff, // events per pin
  output logic [piu_pkg::PIU_NPINS-1:0] wake_seen_ff // sticky wake marks
);
  import piu_pkg::*;
  logic [PIU_NPINS-1:0] prev_ev_ff; // last event level

  // count each rising event line, one counter per pin line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ev_ff <= '0;
      ev_cnt_ff <= '0;
    end else begin
      prev_ev_ff <= pin_event;
      for (int i = 0; i < PIU_NPINS; i++) begin
        if (pin_event[i] && !prev_ev_ff[i]) begin
          ev_cnt_ff[i] <= ev_cnt_ff[i] + 8'h01;
        end
      end
    end
  end

  // remember which pins ever asked for wake-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_seen_ff <= '0;
    end else begin
      wake_seen_ff <= wake_seen_ff | pin_wake;
    end
  end
endmodule : piu_host_model

// [tb/piu_top_tb.sv]
`timescale 1ns/1ps
module piu_top_tb;
  import piu_pkg::*;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  localparam int LAT = 9; // wait, above the 4-cycle edge-with-filter flag latency
  localparam logic [7:0] RTAB [0:8] = '{PIU_OFF_CTRL, PIU_OFF_NMICTL,
    PIU_OFF_NMIFLG, PIU_OFF_EVOUT, PIU_OFF_IENSET, PIU_OFF_FLAG,
    PIU_OFF_WAKE, PIU_OFF_CFG0, PIU_OFF_CFG1}; // resettable registers
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1; // clock enable, lowered in the freeze test
  logic dbg_access = 1'b0;
  logic guard_lock = 1'b0;
  logic [15:0] ext_irq_pin = '0;
  logic nonmask_pin = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1; // always ready for answers
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [15:0] pin_irq, pin_event, pin_wake, wake_seen;
  logic nonmask_irq, detect_clk_req;
  logic [15:0][7:0] ev_cnt;
  int bad_count = 0;
  int check_count = 0;

  always #2 aclk = ~aclk; // 250 MHz

  piu_top #(.NPINS(PIU_NPINS)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(clk_en), .dbg_access(dbg_access), .guard_lock(guard_lock),
    .ext_irq_pin(ext_irq_pin), .nonmask_pin(nonmask_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_irq(pin_irq), .nonmask_irq(nonmask_irq),
    .pin_event(pin_event), .pin_wake(pin_wake),
    .detect_clk_req(detect_clk_req));

  piu_host_model u_host (.aclk(aclk), .aresetn(aresetn),
    .pin_event(pin_event), .pin_wake(pin_wake), .ev_cnt_ff(ev_cnt),
    .wake_seen_ff(wake_seen));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare and count, report at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // register index to byte address
  function automatic logic [31:0] ba(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ba

  // one write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    awaddr <= ba(idx);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
  endtask : wr

  // one read, data taken at the edge where rvalid is seen
  task automatic rd_reg(input logic [7:0] idx);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask : rd_reg

  // read and compare
  task automatic chk_reg(input logic [7:0] idx, input logic [31:0] exp);
    rd_reg(idx);
    chk(rd, exp);
  endtask : chk_reg

  // let some clocks pass
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // verdict and end of run
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(5000);
    bad_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    aresetn <= 1'b1;
    chk({16'h0, pin_irq}, 32'h0);
    for (int i = 0; i < 9; i++) chk_reg(RTAB[i], PIU_RST_WORD);
    rd_reg(8'h05); // unmapped hole
    chk({rd[29:0], rsp}, {30'h0, PIU_RESP_ERR});
    wr(8'h05, 32'hffff_ffff);
    chk({30'h0, rsp}, {30'h0, PIU_RESP_ERR});
    // configure first, then enable
    wr(PIU_OFF_EVOUT, 32'h1);
    wr(PIU_OFF_WAKE, 32'h2);
    wr(PIU_OFF_CFG0, 32'h0095_4321);
    wr(PIU_OFF_CTRL, 32'h2);
    chk({30'h0, rsp}, {30'h0, PIU_RESP_OK});
    chk_reg(PIU_OFF_CTRL, 32'h2);
    cyc(LAT);
    chk_reg(PIU_OFF_FLAG, 32'h10);
    chk({16'h0, pin_irq}, 32'h0);
    chk({31'h0, detect_clk_req}, 32'h1);
    wr(PIU_OFF_IENSET, 32'h3f);
    cyc(3);
    chk({16'h0, pin_irq}, 32'h10);
    wr(PIU_OFF_FLAG, 32'h10);
    chk_reg(PIU_OFF_FLAG, 32'h10);
    // all senses at once
    ext_irq_pin <= 16'h003f;
    cyc(LAT);
    chk_reg(PIU_OFF_FLAG, 32'h3d);
    chk({24'h0, ev_cnt[0]}, 32'h1);
    wr(PIU_OFF_FLAG, 32'h3f);
    cyc(3);
    chk_reg(PIU_OFF_FLAG, 32'h08);
    ext_irq_pin <= 16'h0000;
    cyc(LAT);
    chk_reg(PIU_OFF_FLAG, 32'h1e);
    chk({16'h0, pin_irq}, 32'h1e);
    chk({16'h0, wake_seen}, 32'h2);
    chk({24'h0, ev_cnt[1]}, 32'h0);
    wr(PIU_OFF_IENCLR, 32'h2);
    cyc(3);
    chk({16'h0, pin_irq}, 32'h1c);
    chk_reg(PIU_OFF_IENSET, 32'h3d);
    // glitch: filtered pin drops it, plain pin keeps it
    wr(PIU_OFF_FLAG, 32'hffff);
    ext_irq_pin <= 16'h0021;
    cyc(1);
    ext_irq_pin <= 16'h0000;
    cyc(LAT);
    chk_reg(PIU_OFF_FLAG, 32'h11);
    ext_irq_pin <= 16'h0020;
    cyc(2);
    ext_irq_pin <= 16'h0000;
    cyc(LAT);
    chk_reg(PIU_OFF_FLAG, 32'h31);
    chk({24'h0, ev_cnt[0]}, 32'h2);
    // write guard: flags still clearable, debugger passes
    guard_lock <= 1'b1;
    wr(PIU_OFF_EVOUT, 32'hffff);
    wr(PIU_OFF_FLAG, 32'hffff);
    chk_reg(PIU_OFF_EVOUT, 32'h1);
    chk_reg(PIU_OFF_FLAG, 32'h10);
    dbg_access <= 1'b1;
    wr(PIU_OFF_EVOUT, 32'h3);
    dbg_access <= 1'b0;
    guard_lock <= 1'b0;
    chk_reg(PIU_OFF_EVOUT, 32'h3);
    // disabled unit ignores pins, non-maskable still works
    wr(PIU_OFF_CTRL, 32'h0);
    wr(PIU_OFF_FLAG, 32'hffff);
    ext_irq_pin <= 16'h0001;
    cyc(LAT);
    chk_reg(PIU_OFF_FLAG, 32'h0);
    wr(PIU_OFF_NMICTL, {29'h0, PIU_SNS_RISE});
    nonmask_pin <= 1'b1;
    cyc(LAT);
    chk({31'h0, nonmask_irq}, 32'h1);
    chk_reg(PIU_OFF_NMIFLG, 32'h1);
    wr(PIU_OFF_NMIFLG, 32'h0);
    chk_reg(PIU_OFF_NMIFLG, 32'h1);
    wr(PIU_OFF_NMIFLG, 32'h1);
    cyc(3);
    chk_reg(PIU_OFF_NMIFLG, 32'h0);
    chk({31'h0, nonmask_irq}, 32'h0);
    // frozen unit misses a pin edge that comes and goes meanwhile
    clk_en <= 1'b0;
    nonmask_pin <= 1'b0;
    cyc(LAT);
    nonmask_pin <= 1'b1;
    cyc(LAT);
    clk_en <= 1'b1;
    cyc(LAT);
    chk({31'h0, nonmask_irq}, 32'h0);
    // soft reset returns every mapped register except STATUS (busy) to reset values
    wr(PIU_OFF_CTRL, 32'h1);
    cyc(4);
    for (int i = 0; i < 9; i++) chk_reg(RTAB[i], PIU_RST_WORD);
    chk({31'h0, detect_clk_req}, 32'h0);
    chk({16'h0, pin_irq}, 32'h0);
    finish_test();
  end
endmodule : piu_top_tb
